// >>> include/carm_pkg.sv
package carm_pkg;
    localparam logic [5:0] CARM_ADDR_CA_REF     = 6'h0C;
    localparam logic [5:0] CARM_ADDR_SP_CTRL    = 6'h0D;
    localparam int         CARM_LEVEL_LSB       = 0;
    localparam int         CARM_LEVEL_W         = 6;
    localparam int         CARM_RANGE_BIT       = 6;
    localparam int         CARM_VARIANT_BIT     = 7;
    localparam int         CARM_SP_WR_BIT       = 6;
    localparam int         CARM_SP_OP_BIT       = 7;
    localparam logic [5:0] CARM_LEVEL_RST       = 6'h0D;
    localparam logic       CARM_RANGE_RST       = 1'b1;
    localparam logic       CARM_VARIANT_RST     = 1'b0;
    localparam logic [5:0] CARM_LEVEL_MAX       = 6'h32;
    localparam logic [7:0] CARM_SP_CTRL_RST     = 8'h00;
    localparam int         CARM_RD_LAT          = 4;
    localparam int         CARM_DQ_W            = 16;
    // reference in units of 0.1 percent of supply
    localparam logic [9:0] CARM_BASE_R0         = 10'd100;
    localparam logic [9:0] CARM_BASE_R1         = 10'd220;
    localparam logic [9:0] CARM_STEP            = 10'd4;
endpackage

// >>> logic/carm_ca_ref_mr.sv
// Operation
// - read drives eight bits on low lanes, other lanes zero
// - level write goes to set point chosen by write-select
// - bit 6 picks reference range, range 1 default
// - range holds until rewritten or reset
// - two copies; reads and writes reach write-select copy only
// - operate-select copy alone drives level and range
// - inactive copy may change without disturbing operation
// - variant bit undefined on non-byte parts; controller ignores
// - bit 7 selects training variant, zero default
// - level codes up to 110010, 0.4 percent steps
// - reset gives range 1, level 001101, variant 0
// - write-select bit steers mode register writes
// - operate-select bit picks governing copy
`timescale 1ns/1ps
module carm_ca_ref_mr
    import carm_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 mrw_valid,
    input  wire logic                 mrr_valid,
    input  wire logic [5:0]           mr_addr,
    input  wire logic [7:0]           mr_wdata,
    output logic                      rd_valid,
    output logic      [CARM_DQ_W-1:0] rd_dq,
    output logic      [5:0]           active_level_code,
    output logic                      active_range_select,
    output logic                      active_training_variant,
    output logic                      level_code_reserved,
    output logic      [9:0]           reference_permille
);
    import carm_pkg::*;

    logic [7:0] spc_q;
    logic [7:0] spc_d;
    logic       sp_wr;
    logic       sp_op;
    logic [7:0] copy_val [2];
    logic [1:0] copy_we;
    logic       hit_ref;
    logic [7:0] act;
    logic [7:0] act_q;
    logic [9:0] base;

    assign hit_ref = mr_addr == CARM_ADDR_CA_REF;
    assign sp_wr   = spc_q[CARM_SP_WR_BIT];
    assign sp_op   = spc_q[CARM_SP_OP_BIT];

    // set point control bits tracked locally
    always_comb
    begin
        spc_d = spc_q;
        if (mrw_valid && mr_addr == CARM_ADDR_SP_CTRL)
            spc_d = mr_wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            spc_q <= CARM_SP_CTRL_RST;
        else if (ce)
            spc_q <= spc_d;
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_copy
            assign copy_we[g] = mrw_valid && hit_ref && (sp_wr == 1'(g));
            carm_sp_copy u_copy (
                .clk_sys (clk_sys),
                .rst     (rst),
                .ce      (ce),
                .wr_en   (copy_we[g]),
                .wr_data (mr_wdata),
                .value   (copy_val[g])
            );
        end
    endgenerate

    // read returns write-selected copy
    carm_rd_pipe u_rd (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .in_vld  (mrr_valid && hit_ref),
        .in_data (copy_val[sp_wr]),
        .out_vld (rd_valid),
        .out_dq  (rd_dq)
    );

    assign act = copy_val[sp_op];

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            act_q <= {CARM_VARIANT_RST, CARM_RANGE_RST, CARM_LEVEL_RST};
        else if (ce)
            act_q <= act;
    end

    assign active_level_code       = act_q[CARM_LEVEL_W-1:0];
    assign active_range_select     = act_q[CARM_RANGE_BIT];
    assign active_training_variant = act_q[CARM_VARIANT_BIT];
    assign level_code_reserved     = act_q[5:0] > CARM_LEVEL_MAX;
    assign base = act_q[CARM_RANGE_BIT] ? CARM_BASE_R1 : CARM_BASE_R0;
    assign reference_permille =
        10'(base + CARM_STEP * {4'h0, act_q[5:0]});

    sel_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
        ce && mrw_valid && hit_ref && !sp_wr && mr_wdata[5:0] <= CARM_LEVEL_MAX
        |=> copy_val[0] == $past(mr_wdata))
        else $error("write-select 0 copy not written");
    other_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
        ce && mrw_valid && hit_ref && sp_wr |=> $stable(copy_val[0]))
        else $error("unselected copy changed");
    op_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
        ce |=> act_q == $past(copy_val[sp_op]))
        else $error("active value not from operate copy");
    rd_lat_a: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && mrr_valid && hit_ref) ##1 ce[*4] |-> rd_valid)
        else $error("read latency wrong");
    rd_upper_a: assert property (@(posedge clk_sys) disable iff (rst)
        rd_dq[CARM_DQ_W-1:8] == 8'h00)
        else $error("upper lanes not zero");
    rsv_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        ce && copy_we[1] && mr_wdata[5:0] > CARM_LEVEL_MAX
        |=> copy_val[1][5:0] == $past(copy_val[1][5:0]))
        else $error("reserved level stored");
    rst_val_a: assert property (@(posedge clk_sys)
        rst |=> copy_val[0] == 8'h4D && copy_val[1] == 8'h4D)
        else $error("reset value wrong");
    range_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        !copy_we[0] |=> $stable(copy_val[0][CARM_RANGE_BIT]))
        else $error("range changed without write");
    ref_calc_a: assert property (@(posedge clk_sys) disable iff (rst)
        active_range_select && active_level_code == 6'h0D
        |-> reference_permille == 10'd272)
        else $error("reference level wrong");

    wr1_c: cover property (@(posedge clk_sys) copy_we[1]);
    rd1_c: cover property (@(posedge clk_sys) rd_valid && sp_wr);
    swap_c: cover property (@(posedge clk_sys) sp_op && !sp_wr && copy_we[0]);
endmodule

// >>> logic/carm_rd_pipe.sv
`timescale 1ns/1ps
module carm_rd_pipe
    import carm_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 in_vld,
    input  wire logic [7:0]           in_data,
    output logic                      out_vld,
    output logic      [CARM_DQ_W-1:0] out_dq
);
    logic [CARM_RD_LAT-1:0] vld_q;
    logic [CARM_RD_LAT-1:0] vld_d;
    logic [7:0]             dat_q [CARM_RD_LAT];
    logic [7:0]             dat_d [CARM_RD_LAT];

    always_comb
    begin
        vld_d    = {vld_q[CARM_RD_LAT-2:0], in_vld};
        dat_d[0] = in_data;
        for (int i = 1; i < CARM_RD_LAT; i++)
            dat_d[i] = dat_q[i-1];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            vld_q <= '0;
            for (int i = 0; i < CARM_RD_LAT; i++)
                dat_q[i] <= 8'h00;
        end
        else if (ce)
        begin
            vld_q <= vld_d;
            for (int i = 0; i < CARM_RD_LAT; i++)
                dat_q[i] <= dat_d[i];
        end
    end

    // unused upper lanes forced low
    assign out_vld = vld_q[CARM_RD_LAT-1];
    assign out_dq  = {{(CARM_DQ_W-8){1'b0}}, dat_q[CARM_RD_LAT-1]};
endmodule

// >>> logic/carm_sp_copy.sv
`timescale 1ns/1ps
module carm_sp_copy
    import carm_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] value
);
    logic [5:0] level_q;
    logic [5:0] level_d;
    logic       range_q;
    logic       range_d;
    logic       var_q;
    logic       var_d;

    always_comb
    begin
        level_d = level_q;
        range_d = range_q;
        var_d   = var_q;
        if (wr_en)
        begin
            // reserved codes keep the old level
            if (wr_data[CARM_LEVEL_W-1:0] <= CARM_LEVEL_MAX)
                level_d = wr_data[CARM_LEVEL_W-1:0];
            range_d = wr_data[CARM_RANGE_BIT];
            var_d   = wr_data[CARM_VARIANT_BIT];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            level_q <= CARM_LEVEL_RST;
            range_q <= CARM_RANGE_RST;
            var_q   <= CARM_VARIANT_RST;
        end
        else if (ce)
        begin
            level_q <= level_d;
            range_q <= range_d;
            var_q   <= var_d;
        end
    end

    assign value = {var_q, range_q, level_q};
endmodule

// >>> testbench/carm_ca_ref_mr_bench.sv
`timescale 1ns/1ps
module carm_ca_ref_mr_bench;
    import carm_pkg::*;
    logic                 clk_sys, rst, ce, mrw_valid, mrr_valid, rd_valid;
    logic                 rng, vrt, resv;
    logic [5:0]           mr_addr, lvl;
    logic [7:0]           mr_wdata, d, ctl;
    logic [7:0]           cp [2];
    logic [CARM_DQ_W-1:0] rd_dq;
    logic [9:0]           pm;
    logic [15:0]          q;
    int                   err_total, checks, seed, lat, i;
    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;
    carm_ca_ref_mr i_carm_ca_ref_mr (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr),
        .mr_wdata(mr_wdata), .rd_valid(rd_valid), .rd_dq(rd_dq),
        .active_level_code(lvl), .active_range_select(rng),
        .active_training_variant(vrt), .level_code_reserved(resv),
        .reference_permille(pm));
    carm_ctrl_model i_carm_ctrl_model (.clk_sys(clk_sys),
        .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr),
        .mr_wdata(mr_wdata), .rd_valid(rd_valid), .rd_dq(rd_dq));
    task automatic check(input string n, input logic [15:0] s,
                         input logic [15:0] e);
        checks++;
        if (s !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [9:0] pmil(input logic [7:0] v);
        return (v[6] ? CARM_BASE_R1 : CARM_BASE_R0) + CARM_STEP * {4'h0, v[5:0]};
    endfunction
    task automatic model_rst();
        ctl = CARM_SP_CTRL_RST;
        cp[0] = {CARM_VARIANT_RST, CARM_RANGE_RST, CARM_LEVEL_RST};
        cp[1] = cp[0];
    endtask
    task automatic mwr(input logic [5:0] a, input logic [7:0] v);
        i_carm_ctrl_model.wr(a, v);
        if (a == CARM_ADDR_SP_CTRL)
            ctl = v;
        if (a == CARM_ADDR_CA_REF)
            cp[ctl[6]] = {v[7:6], v[5:0] > CARM_LEVEL_MAX ? cp[ctl[6]][5:0] : v[5:0]};
    endtask
    task automatic chk_all();
        i_carm_ctrl_model.rd(CARM_ADDR_CA_REF, q, lat);
        check("read data", q, {8'h00, cp[ctl[6]]});
        check("read latency", lat[15:0], 16'(CARM_RD_LAT));
        check("active", {8'h00, vrt, rng, lvl}, {8'h00, cp[ctl[7]]});
        check("permille", {6'h00, pm}, {6'h00, pmil(cp[ctl[7]])});
        check("reserved", {15'h0, resv}, 16'h0000);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #400000;
        err_total++;
        end_of_test();
    end
    initial
    begin
        seed = 13445;
        err_total = 0;
        checks = 0;
        rst = 1'b1;
        ce = 1'b1;
        model_rst();
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        chk_all();
        $display("test reset done");
        for (i = 0; i < 40; i++)
        begin
            mwr(CARM_ADDR_SP_CTRL, {i[1:0], 6'h00});
            d = $random(seed);
            mwr(CARM_ADDR_CA_REF, d);
            chk_all();
        end
        $display("test random done");
        mwr(CARM_ADDR_CA_REF, 8'h32);
        chk_all();
        mwr(CARM_ADDR_CA_REF, 8'h33);
        chk_all();
        mwr(6'h0E, 8'hFF);
        chk_all();
        // write with clock enable low must be ignored
        @(posedge clk_sys);
        ce <= 1'b0;
        i_carm_ctrl_model.wr(CARM_ADDR_CA_REF, 8'h05);
        ce <= 1'b1;
        chk_all();
        $display("test corner done");
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        model_rst();
        chk_all();
        $display("test second reset done");
        end_of_test();
    end
endmodule

// >>> testbench/carm_ctrl_model.sv
`timescale 1ns/1ps
module carm_ctrl_model
    import carm_pkg::*;
(
    input  wire logic                 clk_sys,
    output logic                      mrw_valid,
    output logic                      mrr_valid,
    output logic      [5:0]           mr_addr,
    output logic      [7:0]           mr_wdata,
    input  wire logic                 rd_valid,
    input  wire logic [CARM_DQ_W-1:0] rd_dq
);
    initial
    begin
        mrw_valid = 1'b0;
        mrr_valid = 1'b0;
        mr_addr   = 6'h00;
        mr_wdata  = 8'h00;
    end
    // range always sent in the same byte as the level
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        mrw_valid <= 1'b1;
        mr_addr   <= a;
        mr_wdata  <= d;
        @(posedge clk_sys);
        mrw_valid <= 1'b0;
        mr_addr   <= ~a;
        mr_wdata  <= ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] q,
                      output int lat);
        lat = 1;
        @(posedge clk_sys);
        mrr_valid <= 1'b1;
        mr_addr   <= a;
        @(posedge clk_sys);
        mrr_valid <= 1'b0;
        mr_addr   <= ~a;
        do
        begin
            @(posedge clk_sys);
            #1;
            lat++;
        end
        while (rd_valid !== 1'b1 && lat < 12);
        q = rd_dq;
    endtask
endmodule
